// ==== design/suc_core.sv ====
// Purpose: UART core steered by 16-bit host frames on a serial port
// Assumes: Serial clock is its own domain; frames land on CS rise
// Notes:   Answer words freeze while chip select is low
// Summary of operation
// - Serial port works with clock idling low and first-edge sampling.
// - Each frame moves sixteen bits in and sixteen bits out together.
// - First two received bits choose config write/read or data write/read.
// - Input bits taken on rising clock; host samples output on rising clock.
// - Top output bit shows at select fall, rest change on falling clock.
// - Select rising before sixteenth bit aborts frame without register update.
// - Frame effects and register clearing happen at select rise ending frame.
// - Every select fall starts a new sixteen-bit frame.
// - Serial output floats while select high; irq and tx stay driven.
// - Four-bit baud divisor, zero at reset, read back on config reads.
// - Clear-to-send pin reported inverted; zero means pin high.
// - Data write loads eight bits plus extra bit; top bit ignored in seven-bit mode.
// - Data read returns received char, zero at reset; bit 7 zero if 7-bit.
// - Active-low FIFO enable, zero at reset, bypasses 8-deep FIFO when one.
// - Infrared bit selects pulse timing, zero at reset, readable.
// - Word-length bit picks eight or seven bits, plus extra bit if enabled.
// - Extra bit enabled sends host-written extra bit unchanged, no parity.
// - Extra received bit stored with char when enabled, else reads zero.
// - FIFO enable setting readable through config read.
// - Received extra bit set flags an address character interrupt.
// - Zero at first stop bit flags framing error; receiver hunts start again.
`timescale 1ns/1ns
module suc_core #(
    parameter int FIFO_DEPTH = suc_pkg::FIFO_DEPTH,
    parameter int BAUD_BASE  = 1
) (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic mosi,
    input  wire logic rxd,
    input  wire logic cts_n,
    output logic      miso,
    output logic      miso_oe,
    output logic      txd,
    output logic      irq_oe
);
    localparam int PW = $clog2(FIFO_DEPTH);
    localparam int S_CS = 0;
    localparam int S_TGL = 1;
    localparam int S_RX = 2;
    localparam int S_CTS = 3;

    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_EXTRA, RX_STOP
    } suc_rx_st_t;
    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_EXTRA, TX_STOP
    } suc_tx_st_t;

    // Link side
    logic [15:0] rx_word;
    logic [15:0] cfg_word;
    logic [15:0] data_word;
    logic        done_tgl;

    suc_spi_link u_link (
        .nrst      (nrst),
        .sclk      (sclk),
        .cs_n      (cs_n),
        .mosi      (mosi),
        .cfg_word  (cfg_word),
        .data_word (data_word),
        .rx_word   (rx_word),
        .done_tgl  (done_tgl),
        .miso      (miso),
        .miso_oe   (miso_oe)
    );

    // Two-stage synchronisers for select, word toggle, receive line and clear-to-send
    logic [3:0] meta;
    logic [3:0] sync;
    logic       cs_d;
    logic       tgl_d;
    wire  [3:0] async_in = {cts_n, rxd, done_tgl, cs_n};

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            meta  <= suc_pkg::SYNC_RST;
            sync  <= suc_pkg::SYNC_RST;
            cs_d  <= 1'b1;
            tgl_d <= 1'b0;
        end
        else
        begin
            meta  <= async_in;
            sync  <= meta;
            cs_d  <= sync[S_CS];
            tgl_d <= sync[S_TGL];
        end
    end

    wire cs_rise  = sync[S_CS] & ~cs_d;
    wire cs_fall  = ~sync[S_CS] & cs_d;
    wire tgl_edge = sync[S_TGL] ^ tgl_d;

    // A full word waits for the select rise that closes its frame
    logic pending;
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            pending <= 1'b0;
        else if (tgl_edge)
            pending <= 1'b1;
        else if (cs_fall || cs_rise)
            pending <= 1'b0;
    end

    suc_pkg::suc_cfg_frame_t  in_cfg;
    suc_pkg::suc_data_frame_t in_data;
    assign in_cfg  = rx_word;
    assign in_data = rx_word;

    wire commit   = cs_rise & pending;
    wire do_wcfg  = commit && in_cfg.kind == suc_pkg::FT_WCFG;
    wire do_wdata = commit && in_cfg.kind == suc_pkg::FT_WDATA;
    wire do_rdata = commit && in_cfg.kind == suc_pkg::FT_RDATA;

    // Configuration
    suc_pkg::suc_cfg_t cfg;
    suc_pkg::suc_cfg_t next_cfg;
    assign next_cfg = {in_cfg.fifo_enable_n, in_cfg.infrared_timing_sel,
                       in_cfg.len7, in_cfg.extra_bit_enable,
                       in_cfg.baud_divisor_sel};

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            cfg <= suc_pkg::CFG_RESET;
        else if (do_wcfg)
            cfg <= next_cfg;
    end

    wire       ir    = cfg.infrared_timing_sel;
    wire       xen   = cfg.extra_bit_enable;
    wire [2:0] nlast = cfg.len7 ? suc_pkg::BITS_7 : suc_pkg::BITS_8;

    // Oversampling tick from the baud divisor
    logic [23:0] bcnt;
    wire  [23:0] bper = 24'(BAUD_BASE) << cfg.baud_divisor_sel;
    wire         tick = bcnt >= bper - 24'h1;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            bcnt <= '0;
        else
            bcnt <= tick ? 24'h0 : bcnt + 24'h1;
    end

    // Infrared receive: a short high pulse stands for a zero bit
    // Armed only in infrared mode, so entering it finds no stale pulse
    logic [4:0] ir_str;
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            ir_str <= '0;
        else if (sync[S_RX] && ir)
            ir_str <= 5'(suc_pkg::OVERSAMPLE);
        else if (tick && ir_str != 5'h0)
            ir_str <= ir_str - 5'h1;
    end
    wire rxe = ir ? (ir_str == 5'h0) : sync[S_RX];

    // Receiver
    suc_rx_st_t rx_st;
    logic [3:0] rx_tk;
    logic [2:0] rx_bit;
    logic [7:0] rx_char_bits;
    logic       rx_extra_bit;
    wire        rx_mid = tick && rx_tk == suc_pkg::TK_LAST;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            rx_st        <= RX_IDLE;
            rx_tk        <= '0;
            rx_bit       <= '0;
            rx_char_bits <= '0;
            rx_extra_bit <= 1'b0;
        end
        else if (tick)
        begin
            rx_tk <= rx_tk + 4'h1;
            case (rx_st)
                RX_IDLE:
                    if (!rxe)
                    begin
                        rx_st        <= RX_START;
                        rx_tk        <= '0;
                        rx_char_bits <= '0;
                        rx_extra_bit <= 1'b0;
                    end
                RX_START:
                    if (rx_tk == suc_pkg::TK_HALF)
                    begin
                        rx_st  <= rxe ? RX_IDLE : RX_DATA;
                        rx_tk  <= '0;
                        rx_bit <= '0;
                    end
                RX_DATA:
                    if (rx_mid)
                    begin
                        rx_char_bits[rx_bit] <= rxe;
                        rx_bit <= rx_bit + 3'h1;
                        if (rx_bit == nlast)
                            rx_st <= xen ? RX_EXTRA : RX_STOP;
                    end
                RX_EXTRA:
                    if (rx_mid)
                    begin
                        rx_extra_bit <= rxe;
                        rx_st        <= RX_STOP;
                    end
                RX_STOP:
                    if (rx_mid)
                        rx_st <= RX_IDLE;
                default:
                    rx_st <= RX_IDLE;
            endcase
        end
    end

    wire at_stop = rx_st == RX_STOP && rx_mid;
    wire rx_push = at_stop && rxe;
    wire fe_evt  = at_stop && !rxe;
    suc_pkg::suc_char_t push_word;
    assign push_word = {rx_extra_bit & xen, rx_char_bits};

    logic frame_err;
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            frame_err <= 1'b0;
        else if (fe_evt)
            frame_err <= 1'b1;
        else if (rx_push || do_wcfg)
            frame_err <= 1'b0;
    end

    // Receive FIFO; depth one when bypassed
    suc_pkg::suc_char_t mem [FIFO_DEPTH];
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0]   count;
    wire  [PW:0]   limit = cfg.fifo_enable_n ? (PW+1)'(1)
                                             : (PW+1)'(FIFO_DEPTH);
    wire           push_ok = rx_push && count < limit;
    wire           rx_avail = count != '0;
    wire           pop = (do_rdata || do_wdata) && rx_avail;
    suc_pkg::suc_char_t head;
    assign head = mem[rp];

    genvar gi;
    generate
        for (gi = 0; gi < FIFO_DEPTH; gi++)
        begin : g_ent
            always_ff @(posedge clock or negedge nrst)
            begin
                if (!nrst)
                    mem[gi] <= '0;
                else if (push_ok && wp == PW'(gi))
                    mem[gi] <= push_word;
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            wp    <= '0;
            rp    <= '0;
            count <= '0;
        end
        else
        begin
            if (push_ok)
                wp <= wp + 1'b1;
            if (pop)
                rp <= rp + 1'b1;
            count <= count + (PW+1)'(push_ok) - (PW+1)'(pop);
        end
    end

    // Address character flag drives the open-drain interrupt
    logic addr_flag;
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            addr_flag <= 1'b0;
        else if (push_ok && push_word.extra_bit)
            addr_flag <= 1'b1;
        else if (do_rdata)
            addr_flag <= 1'b0;
    end

    // Transmitter
    suc_pkg::suc_char_t tx_buf;
    logic       tx_full;
    suc_tx_st_t tx_st;
    logic [3:0] tx_tk;
    logic [2:0] tx_bit;
    logic [7:0] tx_char_bits;
    logic       tx_extra_bit;
    wire        tx_take = tick && tx_st == TX_IDLE && tx_full;
    wire        tx_end = tick && tx_tk == suc_pkg::TK_LAST;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_buf  <= '0;
            tx_full <= 1'b0;
        end
        else if (do_wdata)
        begin
            tx_buf  <= in_data.data;
            tx_full <= 1'b1;
        end
        else if (tx_take)
            tx_full <= 1'b0;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_st        <= TX_IDLE;
            tx_tk        <= '0;
            tx_bit       <= '0;
            tx_char_bits <= '0;
            tx_extra_bit <= 1'b0;
        end
        else if (tick)
        begin
            tx_tk <= tx_tk + 4'h1;
            case (tx_st)
                TX_IDLE:
                    if (tx_full)
                    begin
                        tx_st        <= TX_START;
                        tx_tk        <= '0;
                        tx_char_bits <= tx_buf.char_bits;
                        tx_extra_bit <= tx_buf.extra_bit;
                    end
                TX_START:
                    if (tx_end)
                    begin
                        tx_st  <= TX_DATA;
                        tx_bit <= '0;
                    end
                TX_DATA:
                    if (tx_end)
                    begin
                        tx_bit <= tx_bit + 3'h1;
                        if (tx_bit == nlast)
                            tx_st <= xen ? TX_EXTRA : TX_STOP;
                    end
                TX_EXTRA:
                    if (tx_end)
                        tx_st <= TX_STOP;
                TX_STOP:
                    if (tx_end)
                        tx_st <= TX_IDLE;
                default:
                    tx_st <= TX_IDLE;
            endcase
        end
    end

    logic line;
    always_comb
    begin
        case (tx_st)
            TX_START: line = 1'b0;
            TX_DATA:  line = tx_char_bits[tx_bit];
            TX_EXTRA: line = tx_extra_bit;
            default:  line = 1'b1;
        endcase
    end
    wire ir_line = ~line && tx_tk < suc_pkg::IR_PULSE_TICKS;

    // Answer words only change while chip select is idle
    logic cts_bit;
    suc_pkg::suc_cfg_frame_t  out_cfg;
    suc_pkg::suc_data_frame_t out_data;
    assign out_cfg  = {rx_avail, ~tx_full, cfg.fifo_enable_n,
                       cfg.infrared_timing_sel, cfg.len7, xen, cts_bit,
                       5'h00, cfg.baud_divisor_sel};
    assign out_data = {rx_avail, ~tx_full, 3'h0, frame_err, cts_bit,
                       head};

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            cfg_word  <= '0;
            data_word <= '0;
            cts_bit   <= 1'b0;
            txd       <= 1'b1;
            irq_oe    <= 1'b0;
        end
        else
        begin
            cts_bit <= ~sync[S_CTS];
            txd     <= ir ? ir_line : line;
            irq_oe  <= addr_flag;
            if (sync[S_CS] && cs_d)
            begin
                cfg_word  <= out_cfg;
                data_word <= out_data;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    chk_cfg_only_commit: assert property (
        $changed(cfg) |-> $past(do_wcfg))
        else $error("configuration changed outside a complete frame");

    chk_cts_inverted: assert property (
        $fell(sync[S_CTS]) |=> cts_bit)
        else $error("clear-to-send bit not inverted");

    chk_fifo_limit: assert property (
        count <= limit)
        else $error("receive buffer over its depth");

    chk_len7_top_zero: assert property (
        (rx_push && cfg.len7) |-> !push_word.char_bits[7])
        else $error("top received bit set in seven-bit mode");

    chk_extra_off_zero: assert property (
        (rx_push && !xen) |-> !push_word.extra_bit)
        else $error("extra received bit stored while disabled");

    chk_start_low: assert property (
        (tx_st == TX_START && !ir) |=> !txd)
        else $error("start bit not low");

    chk_frame_err_set: assert property (
        fe_evt |=> frame_err && rx_st == RX_IDLE)
        else $error("framing error not flagged or receiver not reset");

    chk_addr_irq: assert property (
        (push_ok && push_word.extra_bit && !do_rdata) |-> ##2 irq_oe)
        else $error("address character gave no interrupt");

    chk_wdata_loads: assert property (
        do_wdata |=> tx_full && tx_buf == $past(in_data.data))
        else $error("data write did not load transmit buffer");

    cov_wcfg: cover property (do_wcfg);
    cov_rdata_pop: cover property (do_rdata && rx_avail);
    cov_frame_err: cover property (fe_evt);
    cov_fifo_full: cover property (count == limit && !cfg.fifo_enable_n);
endmodule // suc_core

// ==== design/suc_pkg.sv ====
// Purpose: Shared constants and frame layouts of the serial hosted UART
// Assumes: 16-bit host frames, 16x oversampled asynchronous bit timing
// Notes:   Frame kind sits in the two first bits sent by the host
package suc_pkg;
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 5;
    localparam int KIND_BIT_IDX = 1;
    localparam logic [1:0] FT_WCFG = 2'h3;
    localparam logic [1:0] FT_RCFG = 2'h1;
    localparam logic [1:0] FT_WDATA = 2'h2;
    localparam logic [1:0] FT_RDATA = 2'h0;
    localparam int FIFO_DEPTH = 8;
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] TK_HALF = 4'(OVERSAMPLE / 2 - 1);
    localparam logic [3:0] TK_LAST = 4'(OVERSAMPLE - 1);
    localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
    localparam logic [2:0] BITS_7 = 3'h6;
    localparam logic [2:0] BITS_8 = 3'h7;
    localparam logic [3:0] SYNC_RST = 4'hD;

    typedef struct packed {
        logic       fifo_enable_n;
        logic       infrared_timing_sel;
        logic       len7;
        logic       extra_bit_enable;
        logic [3:0] baud_divisor_sel;
    } suc_cfg_t;

    localparam suc_cfg_t CFG_RESET = '0;

    typedef struct packed {
        logic       extra_bit;
        logic [7:0] char_bits;
    } suc_char_t;

    typedef struct packed {
        logic [1:0] kind;
        logic       fifo_enable_n;
        logic       infrared_timing_sel;
        logic       len7;
        logic       extra_bit_enable;
        logic       cts_bit;
        logic [4:0] rsvd;
        logic [3:0] baud_divisor_sel;
    } suc_cfg_frame_t;

    typedef struct packed {
        logic [1:0] kind;
        logic [2:0] rsvd;
        logic       activity_or_frame_err;
        logic       cts_bit;
        suc_char_t  data;
    } suc_data_frame_t;
endpackage

// ==== design/suc_spi_link.sv ====
// Purpose: Serial port shifter on the host serial clock
// Assumes: Clock idles low, data taken on rising edges, 16-bit frames
// Notes:   Answer words are held static by the core while a frame runs
`timescale 1ns/1ns
module suc_spi_link (
    input  wire logic        nrst,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        mosi,
    input  wire logic [15:0] cfg_word,
    input  wire logic [15:0] data_word,
    output logic      [15:0] rx_word,
    output logic             done_tgl,
    output logic             miso,
    output logic             miso_oe
);
    logic [suc_pkg::CNT_W-1:0] bit_cnt;
    logic [14:0]               sh;
    logic [3:0]                out_idx;
    logic                      is_cfg;
    wire                       last_bit;
    wire                       full_cnt;

    assign last_bit = bit_cnt == suc_pkg::CNT_W'(suc_pkg::FRAME_BITS - 1);
    assign full_cnt = bit_cnt == suc_pkg::CNT_W'(suc_pkg::FRAME_BITS);

    // Chip select high clears the frame, so every low phase starts afresh
    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
        begin
            bit_cnt <= '0;
            sh      <= '0;
            is_cfg  <= 1'b0;
        end
        else
        begin
            if (!full_cnt)
                bit_cnt <= bit_cnt + 1'b1;
            sh <= {sh[13:0], mosi};
            if (bit_cnt == suc_pkg::CNT_W'(suc_pkg::KIND_BIT_IDX))
                is_cfg <= mosi;
        end
    end

    // Word is handed over only once the sixteenth bit is in
    always_ff @(posedge sclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rx_word  <= '0;
            done_tgl <= 1'b0;
        end
        else if (last_bit)
        begin
            rx_word  <= {sh, mosi};
            done_tgl <= ~done_tgl;
        end
    end

    always_ff @(negedge sclk or posedge cs_n)
    begin
        if (cs_n)
            out_idx <= 4'(suc_pkg::FRAME_BITS - 1);
        else if (out_idx != 4'h0)
            out_idx <= out_idx - 4'h1;
    end

    // Top two answer bits match in both words, so the kind bit is in time
    assign miso    = is_cfg ? cfg_word[out_idx] : data_word[out_idx];
    assign miso_oe = ~cs_n;

    chk_handover_full: assert property (
        @(posedge sclk) disable iff (cs_n || !nrst)
        $changed(done_tgl) |-> $past(last_bit))
        else $error("frame word handed over before sixteen bits");

    chk_bit_align: assert property (
        @(posedge sclk) disable iff (cs_n || !nrst)
        bit_cnt < suc_pkg::CNT_W'(suc_pkg::FRAME_BITS) |->
            out_idx + 4'(bit_cnt) == 4'(suc_pkg::FRAME_BITS - 1))
        else $error("answer bit out of step with input bit");
endmodule // suc_spi_link

// ==== tb/suc_host_model.sv ====
// Purpose: Host serial master model driving 16-bit frames
// Assumes: Link clock idles low, 80 ns period, MSB first
// Notes:   Link clock runs only inside frames
`timescale 1ns/1ns
module suc_host_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso
);
    initial
    begin
        sclk = 1'b0;
        mosi = 1'b0;
        // A clean rising select clears the link counters before any frame
        cs_n = 1'b0;
        #10 cs_n = 1'b1;
    end

    // Shifts n bits of w out, answer bits taken on rising link clock
    task automatic frame(input logic [15:0] w, input int n,
                         output logic [15:0] r);
        r = 16'h0000;
        cs_n = 1'b0;
        #400;
        for (int i = 0; i < n; i++)
        begin
            mosi = w[15 - i];
            #40 sclk = 1'b1;
            r[15 - i] = miso;
            #40 sclk = 1'b0;
        end
        #300 cs_n = 1'b1;
        mosi = ~mosi;
        #600;
    endtask
endmodule // suc_host_model

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the serial hosted UART core
// Assumes: Baud code 0 gives 16 clocks per character bit
// Notes:   Host frames come from the partner model
`timescale 1ns/1ns
module testbench;
    logic        clock = 1'b0;
    logic        nrst  = 1'b0;
    logic        rxd   = 1'b1;
    logic        cts_n = 1'b1;
    logic        sclk, cs_n, mosi, miso, miso_oe, txd, irq_oe;
    logic [15:0] ans;
    logic [7:0]  chs [3] = '{8'h11, 8'h5A, 8'hC3};
    int          mismatches  = 0;
    int          comparisons = 0;
    int          cycles      = 0;

    // Released answer pin shows the opposite level, so a late enable shows
    wire         miso_pin = miso_oe ? miso : ~miso;

    always #50 clock = ~clock;

    suc_core u_suc_core (.clock(clock), .nrst(nrst), .sclk(sclk),
        .cs_n(cs_n), .mosi(mosi), .rxd(rxd), .cts_n(cts_n),
        .miso(miso), .miso_oe(miso_oe), .txd(txd), .irq_oe(irq_oe));
    suc_host_model u_suc_host_model (.sclk(sclk), .cs_n(cs_n),
        .mosi(mosi), .miso(miso_pin));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic xfer(input logic [15:0] w, input int n = 16);
        u_suc_host_model.frame(w, n, ans);
    endtask

    // Config frame; receive line moves to the new mode's idle level
    task automatic xfer_idle(input logic [15:0] w, input logic lvl);
        fork
            xfer(w);
            begin
                @(posedge cs_n);
                @(posedge clock);
                rxd <= lvl;
            end
        join
    endtask

    // Start bit, n bits LSB first, then the given stop level
    task automatic send_rx(input logic [9:0] v, input int n,
                           input logic stop);
        @(posedge clock);
        rxd <= 1'b0;
        repeat (16) @(posedge clock);
        for (int i = 0; i < n; i++)
        begin
            rxd <= v[i];
            repeat (16) @(posedge clock);
        end
        rxd <= stop;
        repeat (16) @(posedge clock);
        rxd <= 1'b1;
        repeat (32) @(posedge clock);
    endtask

    // Samples txd in mid bit once the start edge is seen
    task automatic watch_tx(input logic [9:0] v, input int n);
        int k = 0;
        while (txd !== 1'b0 && k < 400)
        begin
            @(posedge clock);
            k++;
        end
        repeat (8) @(posedge clock);
        check(txd, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            repeat (16) @(posedge clock);
            check(txd, v[i]);
        end
        repeat (16) @(posedge clock);
        check(txd, 1'b1);
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            close_out();
        end
    end

    initial
    begin
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        repeat (8) @(posedge clock);
        check(miso_oe, 1'b0);
        xfer(16'h4000);
        check(ans, 16'h4000);
        @(posedge clock);
        cts_n <= 1'b0;
        xfer(16'hFFFF, 9);
        xfer(16'h4000);
        check(ans, 16'h4200);
        xfer_idle(16'hF401, 1'b0);
        xfer(16'h4000);
        check(ans, 16'h7601);
        xfer_idle(16'hCC00, 1'b1);
        xfer(16'h4000);
        check(ans, 16'h4E00);
        fork
            xfer(16'h80FF);
            watch_tx(10'h07F, 8);
        join
        send_rx(10'h0FF, 8, 1'b1);
        check(irq_oe, 1'b1);
        xfer(16'h0000);
        check(ans, 16'hC37F);
        repeat (4) @(posedge clock);
        check(irq_oe, 1'b0);
        send_rx(10'h000, 8, 1'b0);
        xfer(16'h0000);
        check(ans & 16'hFE00, 16'h4600);
        xfer(16'hC000);
        for (int i = 0; i < 3; i++)
            send_rx({2'h0, chs[i]}, 8, 1'b1);
        for (int i = 0; i < 3; i++)
        begin
            xfer(16'h0000);
            check(ans, {8'hC2, chs[i]});
        end
        xfer(16'hE000);
        for (int i = 0; i < 2; i++)
            send_rx({2'h0, chs[i]}, 8, 1'b1);
        xfer(16'h0000);
        check(ans, {8'hC2, chs[0]});
        xfer(16'h0000);
        check(ans, 16'h4200);
        check(miso_oe, 1'b0);
        close_out();
    end
endmodule // testbench
